// *** hw/fpx_consts.svh ***
// Constants for the floating-point exception unit: vectors, bit positions, resets.
`ifndef FPX_CONSTS_SVH
`define FPX_CONSTS_SVH

// ----------------------------------------------------------------
// Interrupt vectors
// ----------------------------------------------------------------
`define FPX_VEC_UD      8'h06
`define FPX_VEC_NM      8'h07
`define FPX_VEC_MF      8'h10
`define FPX_VEC_AC      8'h11

// ----------------------------------------------------------------
// Flag bit positions in the status word
// ----------------------------------------------------------------
`define FPX_IE          0
`define FPX_DE          1
`define FPX_ZE          2
`define FPX_OE          3
`define FPX_UE          4
`define FPX_PE          5
`define FPX_SF          6
`define FPX_ES          7
`define FPX_C1          9

// ----------------------------------------------------------------
// Control word fields, reset values and the user privilege level
// ----------------------------------------------------------------
`define FPX_PC_LSB      8
`define FPX_RC_LSB      10
`define FPX_RC_CHOP     2'h3
`define FPX_PREC_EXT    2'h3
`define FPX_CW_RESET    16'h037f
`define FPX_CPL_USER    2'h3

`endif

// *** hw/fpx_pkg.sv ***
// Types shared by the floating-point exception unit and its classifier.
package fpx_pkg;

    typedef enum logic [3:0] {
        OPK_LOAD, OPK_ARITH, OPK_TRANS, OPK_EXTRACT, OPK_SQRT, OPK_DIV,
        OPK_PREM, OPK_CONVERT, OPK_ENV_LOAD, OPK_SAVE, OPK_RESTORE, OPK_OTHER
    } op_kind_t;

    typedef enum logic [1:0] {RES_NORMAL, RES_INF, RES_MAXFIN} ovf_sel_t;

    typedef enum logic [1:0] {FSM_IDLE = 2'b01, FSM_PEND = 2'b10} fsm_t;

    typedef struct packed {
        logic        valid;
        logic        defined;
        op_kind_t    kind;
        logic        mem;
        logic        misaligned;
        logic        stack_part;
        logic        env_first_ok;
        logic        env_last_ok;
        logic [15:0] env_cw;
    } issue_t;

    typedef struct packed {
        logic        valid;
        op_kind_t    kind;
        logic        fixed_prec;
        logic [1:0]  op_prec;
        logic        ignores_pc;
        logic        stack_dest;
        logic        sign;
        logic        denorm_in;
        logic        invalid;
        logic        zdiv;
        logic        ovf;
        logic        tiny;
        logic        lost;
        logic        inexact;
        logic        stk_ovf;
        logic        stk_unf;
        logic [15:0] cs;
        logic [31:0] prefix_ip;
    } result_t;

    typedef struct packed {
        logic        valid;
        logic        normalize;
        logic        exp_adjust;
        ovf_sel_t    sel;
        logic        sign;
        logic [1:0]  prec;
    } resp_t;

    typedef struct packed {
        logic [6:0]  flags;
        logic        c1_set;
        logic        c1_val;
        resp_t       resp;
    } class_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  vector;
    } trap_t;

    typedef struct packed {
        fsm_t        fsm;
        logic [15:0] cw;
        logic [6:0]  flags;
        logic        c1;
        logic        err;
        trap_t       trap;
        logic        go;
        logic        env_commit;
        resp_t       resp;
        logic [15:0] saved_cs;
        logic [31:0] saved_ip;
    } state_t;

endpackage

// *** hw/fp_exc_classify.sv ***
// Classifies one completed operation into exception flags and a result response.
`timescale 1ns/1ns
`include "fpx_consts.svh"
module fp_exc_classify
    import fpx_pkg::*;
(
    input  wire result_t     i_res,
    input  wire logic [15:0] i_cw,
    output class_t           o_cls
);
    logic [5:0] msk;
    logic       arith;
    logic       nrm_op;
    logic       stk;
    logic       ie;
    logic       de;
    logic       ze;
    logic       oe;
    logic       ue;
    logic [1:0] pc;

    always_comb begin
        msk    = i_cw[5:0];
        pc     = i_cw[`FPX_PC_LSB +: 2];
        arith  = !(i_res.kind inside {OPK_LOAD, OPK_ENV_LOAD, OPK_SAVE, OPK_RESTORE, OPK_OTHER});
        nrm_op = i_res.kind inside {OPK_SQRT, OPK_DIV, OPK_PREM, OPK_CONVERT};
        stk    = i_res.stk_ovf | i_res.stk_unf;
        // A denormal input never feeds the invalid flag; only real invalid causes do.
        ie     = i_res.invalid | stk;
        de     = i_res.denorm_in & arith & !ie;
        // Denormal is recorded beside later flags whatever its mask, so order is fixed.
        ze     = i_res.zdiv & !ie;
        oe     = i_res.ovf & !ie & !ze;
        ue     = !ie & !ze & !oe & i_res.tiny & (msk[`FPX_UE] ? i_res.lost : 1'b1);
        o_cls = '0;
        o_cls.flags[`FPX_IE] = ie;
        o_cls.flags[`FPX_SF] = stk;
        o_cls.flags[`FPX_DE] = de;
        o_cls.flags[`FPX_ZE] = ze;
        o_cls.flags[`FPX_OE] = oe;
        o_cls.flags[`FPX_UE] = ue;
        o_cls.flags[`FPX_PE] = !ie & !ze & (i_res.inexact | (oe & !msk[`FPX_OE]));
        o_cls.c1_set    = stk;
        o_cls.c1_val    = i_res.stk_ovf;
        o_cls.resp.valid = i_res.valid;
        o_cls.resp.sign  = i_res.sign;
        o_cls.resp.prec  = `FPX_PREC_EXT;
        o_cls.resp.normalize = de & (msk[`FPX_DE] | nrm_op);
        if (oe && msk[`FPX_OE]) begin
            o_cls.resp.sel = (i_cw[`FPX_RC_LSB +: 2] == `FPX_RC_CHOP) ? RES_MAXFIN : RES_INF;
        end else if (oe && i_res.stack_dest) begin
            o_cls.resp.prec = i_res.fixed_prec ? i_res.op_prec : pc;
        end else if (ue && !msk[`FPX_UE] && i_res.stack_dest) begin
            o_cls.resp.exp_adjust = 1'b1;
            o_cls.resp.prec       = i_res.ignores_pc ? `FPX_PREC_EXT : pc;
        end
    end
endmodule

// *** hw/fp_exception_unit.sv ***
// Floating-point exception unit: issue checks, sticky flags, error pin and traps.
// What this block does
// - Masked denormal operands are normalized by the unit where possible.
// - Transcendental and exponent-extract ops raise the denormal flag too.
// - Masked overflow under chop rounding returns largest finite value of the sign.
// - Unmasked overflow also sets the precision flag.
// - Unmasked overflow to stack rounds to precision field or opcode precision.
// - Masked underflow is flagged only when tiny and accuracy lost.
// - Unmasked underflow to stack adjusts exponent, rounds to field or extended.
// - Denormal flag precedence does not depend on its mask.
// - Saved segment and pointer mark the first prefix byte of the instruction.
// - Errors reach the core directly, not via an interrupt controller.
// - Undefined opcode traps on vector 6.
// - Any opcode traps on vector 7 when task-switched or coprocessor-absent set.
// - Undefined opcode does not check pending floating-point errors.
// - Unmasked exception raises the error pin when its instruction completes.
// - Pending unmasked exception holds off the next floating-point instruction.
// - Denormals to root, divide, remainder, conversions normalize without invalid.
// - Misaligned operand at privilege 3 with checking on faults, save stack exempt.
// - Environment load commits only after first and last bytes are read.
// - Stack fault sets invalid and stack flags, C1 tells overflow or underflow.
// - Floating-point error trap uses vector 16.
`timescale 1ns/1ns
`include "fpx_consts.svh"
module fp_exception_unit
    import fpx_pkg::*;
(
    input  wire  logic        i_clk_sys,
    input  wire  logic        i_rst_n,
    input  wire  issue_t      i_issue,
    input  wire  logic        i_task_switched_flag,
    input  wire  logic        i_coprocessor_absent_flag,
    input  wire  logic        i_align_check_en,
    input  wire  logic [1:0]  i_cpl,
    input  wire  result_t     i_result,
    input  wire  logic        i_cw_wr,
    input  wire  logic [15:0] i_cw,
    input  wire  logic        i_clear_flags,
    output trap_t             o_trap,
    output logic              o_issue_go,
    output logic              o_env_commit,
    output resp_t             o_resp,
    output logic [15:0]       o_status_word,
    output logic [15:0]       o_control_word,
    output logic              o_fp_error_out,
    output logic              o_hold_off,
    output logic [15:0]       o_saved_cs,
    output logic [31:0]       o_saved_ip
);

    // ----------------------------------------------------------------
    // Classification of completing operations
    // ----------------------------------------------------------------
    state_t st_reg;
    state_t st_next;
    class_t cls;
    logic   unmasked;
    logic   dna;

    fp_exc_classify u_classify (
        .i_res (i_result),
        .i_cw  (st_reg.cw),
        .o_cls (cls)
    );

    function automatic logic any_unmasked(input logic [6:0] flags, input logic [15:0] cw);
        any_unmasked = |(flags[5:0] & ~cw[5:0]);
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_next            = st_reg;
        st_next.trap       = '0;
        st_next.go         = 1'b0;
        st_next.env_commit = 1'b0;
        st_next.resp.valid = 1'b0;
        dna                = i_task_switched_flag | i_coprocessor_absent_flag;
        unmasked           = 1'b0;

        // Software clear comes first so that a flag set in the same cycle survives.
        if (i_clear_flags) begin
            st_next.flags = '0;
        end
        if (i_cw_wr) begin
            st_next.cw = i_cw;
        end

        if (i_result.valid) begin
            st_next.flags = st_next.flags | cls.flags;
            st_next.resp  = cls.resp;
            if (cls.c1_set) begin
                st_next.c1 = cls.c1_val;
            end
            if (any_unmasked(cls.flags, st_next.cw)) begin
                st_next.saved_cs = i_result.cs;
                st_next.saved_ip = i_result.prefix_ip;
            end
        end

        if (i_issue.valid) begin
            st_next.trap.valid = 1'b1;
            if (dna) begin
                st_next.trap.vector = `FPX_VEC_NM;
            end else if (!i_issue.defined) begin
                // No look at pending errors here: the opcode never reaches the datapath.
                st_next.trap.vector = `FPX_VEC_UD;
            end else if (st_reg.fsm == FSM_PEND) begin
                // Direct delivery to the core; the pin is only a legacy side path.
                st_next.trap.vector = `FPX_VEC_MF;
            end else if (i_align_check_en && i_cpl == `FPX_CPL_USER && i_issue.mem
                         && i_issue.misaligned && !i_issue.stack_part) begin
                st_next.trap.vector = `FPX_VEC_AC;
            end else begin
                st_next.trap.valid = 1'b0;
                if (i_issue.kind == OPK_ENV_LOAD) begin
                    // Both ends of the image must be readable before any state moves.
                    if (i_issue.env_first_ok && i_issue.env_last_ok) begin
                        st_next.cw         = i_issue.env_cw;
                        st_next.env_commit = 1'b1;
                        st_next.go         = 1'b1;
                    end
                end else begin
                    st_next.go = 1'b1;
                end
            end
        end

        unmasked    = any_unmasked(st_next.flags, st_next.cw);
        st_next.err = unmasked;
        case (st_reg.fsm)
            FSM_IDLE: begin
                if (unmasked) begin
                    st_next.fsm = FSM_PEND;
                end
            end
            FSM_PEND: begin
                if (!unmasked) begin
                    st_next.fsm = FSM_IDLE;
                end
            end
            default: begin
                st_next.fsm = FSM_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_reg     <= '0;
            st_reg.fsm <= FSM_IDLE;
            st_reg.cw  <= `FPX_CW_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all taken from the state register
    // ----------------------------------------------------------------
    always_comb begin
        o_status_word              = 16'h0000;
        o_status_word[6:0]         = st_reg.flags;
        o_status_word[`FPX_ES]     = st_reg.err;
        o_status_word[`FPX_C1]     = st_reg.c1;
    end

    assign o_trap         = st_reg.trap;
    assign o_issue_go     = st_reg.go;
    assign o_env_commit   = st_reg.env_commit;
    assign o_resp         = st_reg.resp;
    assign o_control_word = st_reg.cw;
    assign o_fp_error_out = st_reg.err;
    assign o_hold_off     = st_reg.fsm[1];
    assign o_saved_cs     = st_reg.saved_cs;
    assign o_saved_ip     = st_reg.saved_ip;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    chk_nm_vector: assert property (
        i_issue.valid && (i_task_switched_flag || i_coprocessor_absent_flag)
        |=> o_trap.valid && o_trap.vector == 8'h07 && !o_issue_go)
        else $error("device-unavailable trap missing or wrong vector");

    chk_ud_vector: assert property (
        i_issue.valid && !i_task_switched_flag && !i_coprocessor_absent_flag && !i_issue.defined
        |=> o_trap.valid && o_trap.vector == 8'h06)
        else $error("undefined opcode did not trap on vector 6");

    chk_ud_no_pend: assert property (
        i_issue.valid && !i_task_switched_flag && !i_coprocessor_absent_flag
        && !i_issue.defined && o_hold_off
        |=> o_trap.vector != 8'h10 && !o_issue_go)
        else $error("undefined opcode reported a pending error");

    chk_hold_off: assert property (
        i_issue.valid && i_issue.defined && !i_task_switched_flag
        && !i_coprocessor_absent_flag && o_hold_off
        |=> o_trap.valid && o_trap.vector == 8'h10 && !o_issue_go)
        else $error("instruction ran while an unmasked error was pending");

    chk_err_level: assert property (
        o_fp_error_out == (|(o_status_word[5:0] & ~o_control_word[5:0])))
        else $error("error pin disagrees with unmasked flags");

    chk_ovf_chop: assert property (
        i_result.valid && i_result.ovf && !i_result.invalid && !i_result.zdiv
        && !i_result.stk_ovf && !i_result.stk_unf && o_control_word[3]
        && o_control_word[11:10] == 2'h3 && !i_cw_wr
        |=> o_resp.valid && o_resp.sel == RES_MAXFIN)
        else $error("chop overflow did not return largest finite value");

    chk_ovf_prec: assert property (
        i_result.valid && i_result.ovf && !i_result.invalid && !i_result.zdiv
        && !i_result.stk_ovf && !i_result.stk_unf && !o_control_word[3] && !i_cw_wr
        |=> o_status_word[5] && o_status_word[3] && o_fp_error_out)
        else $error("unmasked overflow left precision flag or pin clear");

    chk_stack_fault: assert property (
        i_result.valid && i_result.stk_ovf && !o_control_word[0] && !i_cw_wr
        |=> o_status_word[0] && o_status_word[6] && o_status_word[9] && o_fp_error_out ##1 o_hold_off)
        else $error("stack overflow flags, C1 or pin wrong");

    chk_env_atomic: assert property (
        i_issue.valid && i_issue.defined && i_issue.kind == OPK_ENV_LOAD && !o_hold_off
        && !i_task_switched_flag && !i_coprocessor_absent_flag
        && !(i_issue.env_first_ok && i_issue.env_last_ok) && !i_cw_wr
        |=> !o_env_commit && o_control_word == $past(o_control_word))
        else $error("environment load changed state without both ends read");

endmodule

// *** verif/fp_irq_ctrl_model.sv ***
// Interrupt controller model that turns the error pin into a maskable interrupt request.
`timescale 1ns/1ns
module fp_irq_ctrl_model (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_fp_error_out,
    input  wire logic i_ack,
    input  wire logic i_slow,
    output logic      o_maskable_irq_input
);
    logic [1:0] delay_reg;

    // The request is level sensitive, so an acknowledge with the pin still high asks again.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            delay_reg            <= 2'h0;
            o_maskable_irq_input <= 1'b0;
        end else if (i_ack) begin
            delay_reg            <= 2'h0;
            o_maskable_irq_input <= 1'b0;
        end else if (i_fp_error_out && !o_maskable_irq_input) begin
            // The slow setting stands for a controller that serves other sources first.
            if (!i_slow || delay_reg == 2'h3) begin
                o_maskable_irq_input <= 1'b1;
            end
            delay_reg <= delay_reg + 2'h1;
        end
    end
endmodule

// *** verif/testbench.sv ***
// Self-checking testbench for the floating-point exception unit.
`timescale 1ns/1ns
`include "fpx_consts.svh"
module testbench
    import fpx_pkg::*;
;
    logic        clk;
    logic        rst_n;
    issue_t      iss;
    result_t     res;
    logic        ts, em, al, cw_wr, clr, ack, slow, go, commit, err, hold, irq;
    logic [1:0]  cpl;
    logic [15:0] cw, sw, cwo, scs;
    logic [31:0] sip;
    trap_t       trap;
    resp_t       resp;
    int          miscompares;
    int          n_compared;
    op_kind_t    kinds [7] = '{OPK_TRANS, OPK_EXTRACT, OPK_SQRT, OPK_DIV, OPK_PREM, OPK_CONVERT, OPK_LOAD};

    fp_exception_unit DUT (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_issue(iss), .i_task_switched_flag(ts),
        .i_coprocessor_absent_flag(em), .i_align_check_en(al), .i_cpl(cpl), .i_result(res),
        .i_cw_wr(cw_wr), .i_cw(cw), .i_clear_flags(clr), .o_trap(trap), .o_issue_go(go),
        .o_env_commit(commit), .o_resp(resp), .o_status_word(sw), .o_control_word(cwo),
        .o_fp_error_out(err), .o_hold_off(hold), .o_saved_cs(scs), .o_saved_ip(sip)
    );

    fp_irq_ctrl_model irq_ctrl (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_fp_error_out(err), .i_ack(ack), .i_slow(slow),
        .o_maskable_irq_input(irq)
    );

    // ----------------------------------------------------------------
    // Compare and access tasks
    // ----------------------------------------------------------------
    task automatic chk1(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Offers one instruction; a zero vector means no trap is expected.
    task automatic issue(input issue_t x, input logic [7:0] vec, input logic go_exp);
        issue_t y;
        y = x;
        y.valid = 1'b1;
        @(negedge clk);
        iss = y;
        @(negedge clk);
        iss.valid = 1'b0;
        chk1(trap.valid, vec != 8'h00, "trap valid");
        chkw(32'(trap.vector), 32'(vec), "trap vector");
        chk1(go, go_exp, "issue go");
    endtask

    task automatic complete(input result_t r);
        result_t y;
        y = r;
        y.valid = 1'b1;
        @(negedge clk);
        res = y;
        @(negedge clk);
        res.valid = 1'b0;
        chk1(resp.valid, 1'b1, "response valid");
    endtask

    task automatic set_cw(input logic [15:0] v);
        @(negedge clk);
        cw = v;
        cw_wr = 1'b1;
        @(negedge clk);
        cw_wr = 1'b0;
    endtask

    task automatic clear_ack();
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        ack = 1'b1;
        @(negedge clk);
        ack = 1'b0;
    endtask

    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq !== exp && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk1(irq, exp, "interrupt request");
        if (irq !== exp) begin
            conclude();
        end
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #200000;
        miscompares++;
        conclude();
    end

    initial begin
        issue_t  x;
        result_t r;
        {iss, res, ts, em, al, cw_wr, clr, ack, slow, cpl, cw} = '0;
        miscompares = 0;
        n_compared = 0;
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chkw(32'(sw), 32'h0, "status after reset");
        chkw(32'(cwo), 32'h037f, "control after reset");
        chk1(err | hold, 1'b0, "error after reset");
        $display("test reset done");

        x = '0;
        x.defined = 1'b1;
        x.kind = OPK_ARITH;
        ts = 1'b1;
        issue(x, `FPX_VEC_NM, 1'b0);
        ts = 1'b0;
        em = 1'b1;
        x.defined = 1'b0;
        issue(x, `FPX_VEC_NM, 1'b0);
        em = 1'b0;
        issue(x, `FPX_VEC_UD, 1'b0);
        x.defined = 1'b1;
        issue(x, 8'h00, 1'b1);
        al = 1'b1;
        cpl = `FPX_CPL_USER;
        x.mem = 1'b1;
        x.misaligned = 1'b1;
        issue(x, `FPX_VEC_AC, 1'b0);
        x.stack_part = 1'b1;
        issue(x, 8'h00, 1'b1);
        x.stack_part = 1'b0;
        cpl = 2'h0;
        issue(x, 8'h00, 1'b1);
        $display("test traps done");

        x = '0;
        x.defined = 1'b1;
        x.kind = OPK_ENV_LOAD;
        x.env_cw = 16'h027f;
        x.env_first_ok = 1'b1;
        issue(x, 8'h00, 1'b0);
        chk1(commit, 1'b0, "env commit");
        x.env_first_ok = 1'b0;
        x.env_last_ok = 1'b1;
        issue(x, 8'h00, 1'b0);
        chkw(32'(cwo), 32'h037f, "control kept");
        x.env_first_ok = 1'b1;
        issue(x, 8'h00, 1'b1);
        chk1(commit, 1'b1, "env commit");
        @(negedge clk);
        chkw(32'(cwo), 32'h027f, "control loaded");
        $display("test environment load done");

        set_cw(16'h0200);
        r = '0;
        r.kind = OPK_ARITH;
        r.ovf = 1'b1;
        r.stack_dest = 1'b1;
        r.cs = 16'h1a2b;
        r.prefix_ip = 32'h0000_4f10;
        complete(r);
        chkw(32'(sw), 32'h00a8, "overflow status");
        chk1(err, 1'b1, "error pin");
        chk1(hold, 1'b1, "hold off");
        chkw(32'(resp.prec), 32'h2, "overflow precision");
        chkw({scs, 16'h0}, 32'h1a2b_0000, "saved segment");
        chkw(sip, 32'h0000_4f10, "saved pointer");
        wait_irq(1'b1);
        x = '0;
        x.defined = 1'b1;
        x.kind = OPK_ARITH;
        issue(x, `FPX_VEC_MF, 1'b0);
        x.defined = 1'b0;
        issue(x, `FPX_VEC_UD, 1'b0);
        clear_ack();
        chk1(err | hold, 1'b0, "error cleared");
        wait_irq(1'b0);
        x.defined = 1'b1;
        issue(x, 8'h00, 1'b1);
        $display("test unmasked overflow done");

        set_cw(16'h0f7f);
        for (int s = 0; s < 2; s++) begin
            r.sign = s[0];
            complete(r);
            chkw(32'(resp.sel), 32'(RES_MAXFIN), "chop overflow result");
            chk1(resp.sign, s[0], "chop overflow sign");
            chk1(err, 1'b0, "masked error pin");
            chk1(sw[`FPX_OE], 1'b1, "masked overflow flag");
            clear_ack();
        end
        $display("test masked overflow done");

        set_cw(16'h037f);
        r = '0;
        r.kind = OPK_ARITH;
        r.tiny = 1'b1;
        r.stack_dest = 1'b1;
        complete(r);
        chk1(sw[`FPX_UE], 1'b0, "tiny exact underflow");
        r.lost = 1'b1;
        complete(r);
        chk1(sw[`FPX_UE], 1'b1, "tiny inexact underflow");
        clear_ack();
        set_cw(16'h0000);
        slow = 1'b1;
        r.ignores_pc = 1'b1;
        complete(r);
        chk1(resp.exp_adjust, 1'b1, "exponent adjust");
        chkw(32'(resp.prec), 32'(`FPX_PREC_EXT), "extended rounding");
        r.ignores_pc = 1'b0;
        complete(r);
        chkw(32'(resp.prec), 32'h0, "field rounding");
        wait_irq(1'b1);
        clear_ack();
        wait_irq(1'b0);
        slow = 1'b0;
        $display("test underflow done");

        set_cw(16'h037f);
        for (int k = 0; k < 7; k++) begin
            r = '0;
            r.kind = kinds[k];
            r.denorm_in = 1'b1;
            complete(r);
            chk1(sw[`FPX_DE], k < 6, "denormal flag");
            chk1(sw[`FPX_IE], 1'b0, "no invalid on denormal");
            if (k < 6) begin
                chk1(resp.normalize, 1'b1, "normalize");
            end
            clear_ack();
        end
        // Invalid unmasked so that the stack fault also drives the pin and hold.
        set_cw(16'h037e);
        r = '0;
        r.stk_ovf = 1'b1;
        complete(r);
        chkw(32'(sw & 16'h0241), 32'h0241, "stack overflow");
        chk1(err, 1'b1, "stack fault pin");
        clear_ack();
        r = '0;
        r.stk_unf = 1'b1;
        complete(r);
        chkw(32'(sw & 16'h0241), 32'h0041, "stack underflow");
        clear_ack();
        $display("test denormal and stack done");

        for (int m = 0; m < 2; m++) begin
            set_cw(m == 0 ? 16'h037d : 16'h037f);
            r = '0;
            r.kind = OPK_ARITH;
            r.denorm_in = 1'b1;
            r.ovf = 1'b1;
            complete(r);
            chkw(32'(sw & 16'h000a), 32'h000a, "denormal beside overflow");
            chk1(err, m == 0, "error follows mask");
            clear_ack();
        end
        $display("test precedence done");

        set_cw(16'h0300);
        r = '0;
        r.ovf = 1'b1;
        complete(r);
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chk1(err | hold, 1'b0, "error after reset");
        chkw(32'(sw), 32'h0, "status after reset");
        chkw(32'(cwo), 32'h037f, "control after reset");
        $display("test reset in run done");
        conclude();
    end
endmodule
